// >>> imc_pkg.sv
/*
 * Constants and carrier types for the instruction-set mode control block.
 * Assumes a single 25 MHz core clock and a synchronous active-low reset.
 */
package imc_pkg;

    // Encoding support field values (config word three, bits 15:14)
    localparam logic [1:0] ENC_ONLY32  = 2'h0;
    localparam logic [1:0] ENC_COMPACT = 2'h1;
    localparam logic [1:0] ENC_BOTH32  = 2'h2;
    localparam logic [1:0] ENC_BOTHCMP = 2'h3;

    // Field positions in config word three
    localparam int CFG_ENC_LSB = 14;
    localparam int CFG_EXC_BIT = 16;

    // Mode values
    localparam logic MODE_32   = 1'h0;
    localparam logic MODE_CMP  = 1'h1;

    // Offset shifts per encoding
    localparam logic [1:0] SHIFT_32  = 2'h2;
    localparam logic [1:0] SHIFT_CMP = 2'h1;

    // Number of virtual processor elements
    localparam int NUM_ELEM = 2;

    // Reset value of config word three, also the base of the built word
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Event kinds that move the mode
    typedef enum logic [2:0] {
        IMC_EV_NONE,
        IMC_EV_EXC,
        IMC_EV_DEBUG,
        IMC_EV_ERROR,
        IMC_EV_JUMP,
        IMC_EV_CALL,
        IMC_EV_RETURN
    } imc_event_t;

    // Return-address register selection
    typedef enum logic [1:0] {
        IMC_RA_EXC,
        IMC_RA_DEBUG,
        IMC_RA_ERROR
    } imc_ra_t;

    // One pipeline event into the block
    typedef struct packed {
        imc_event_t  kind;
        logic [31:0] value;      // Source register or return address
        logic        elem;       // Processor element issuing it
        logic        baseVec;    // Vector is an offset of the vector base
    } imc_req_t;

    // Results toward the pipeline
    typedef struct packed {
        logic [31:0] nextPc;     // Jump target
        logic [31:0] saveWord;   // Value for return or link register
        imc_ra_t     saveSel;    // Which return register is written
        logic        saveEn;     // Return or link register write
        logic        pcEn;       // Program counter load
        logic        addrFault;  // Address fault on target fetch
    } imc_rsp_t;

endpackage : imc_pkg

// >>> imc_mode_control.sv
/*
 * Keeps the one-bit instruction-set mode of the core and the helpers
 * that depend on it: mode save and restore, jump target shaping,
 * branch offset scaling and coprocessor fault selection.
 * Assumes the pipeline presents at most one event per cycle and that
 * strap inputs come from pins and are synchronised here.
 */
module imc_mode_control #(
    parameter logic CMP_COP_AS_RESV = 1'b1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [1:0]       strapEncoding,
    input  wire logic             strapExcMode,
    input  wire logic             strapDebugMode,
    input  wire logic             probeWrite,
    input  wire logic             probeDebugMode,
    input  wire logic             cfgWrite,
    input  wire logic             cfgWriteElem,
    input  wire logic             cfgExcMode,
    input  wire imc_pkg::imc_req_t req,
    input  wire logic             copUnimpl,
    output logic [31:0]           configWordThree,
    output logic                  isaMode,
    output logic                  decodeCompact,
    output logic                  fetchHalfAlign,
    output logic [1:0]            offsetShift,
    output logic                  debugModeSelect,
    output logic                  reservedInstrFault,
    output logic                  copUnusableFault,
    output imc_pkg::imc_rsp_t     rsp
);

    // Strap synchronisers, two stages each
    logic [1:0] encMeta;
    logic [1:0] encSync;
    logic       excMeta;
    logic       excSync;
    logic       dbgMeta;
    logic       dbgSync;
    logic       strapLoad;   // High for the first cycle after reset release
    logic [1:0] encField;
    logic [imc_pkg::NUM_ELEM-1:0] excSelect;
    logic       mode;
    logic       dbgSelect;

    // Double-flop every strap pin
    always_ff @(posedge core_clk)
    begin
        encMeta <= strapEncoding;
        encSync <= encMeta;
        excMeta <= strapExcMode;
        excSync <= excMeta;
        dbgMeta <= strapDebugMode;
        dbgSync <= dbgMeta;
    end

    // Support decode, used for every mode change except the strap load after reset
    function automatic logic supportsBoth(input logic [1:0] enc);
        supportsBoth = enc[1];
    endfunction : supportsBoth

    // Fixed or reset mode from the encoding field
    function automatic logic encMode(input logic [1:0] enc);
        encMode = (enc == imc_pkg::ENC_COMPACT) ||
                  (enc == imc_pkg::ENC_BOTHCMP);
    endfunction : encMode

    wire logic bothEnc   = supportsBoth(encField);
    wire logic fixedMode = encMode(encField);
    wire logic strapMode = encMode(encSync);
    wire imc_pkg::imc_event_t kind = req.kind;
    wire logic srcBit    = req.value[0];
    wire logic isExc     = (kind == imc_pkg::IMC_EV_EXC) ||
                           (kind == imc_pkg::IMC_EV_ERROR);
    wire logic isDebug   = (kind == imc_pkg::IMC_EV_DEBUG);
    wire logic isJump    = (kind == imc_pkg::IMC_EV_JUMP) ||
                           (kind == imc_pkg::IMC_EV_CALL);
    wire logic isCall    = (kind == imc_pkg::IMC_EV_CALL);
    wire logic isReturn  = (kind == imc_pkg::IMC_EV_RETURN);

    wire logic excTarget = req.baseVec ? excSelect[req.elem] : mode;

    // Mode that the next event leaves behind
    logic next_mode;
    always_comb
    begin
        next_mode = mode;
        if (strapLoad)
            next_mode = strapMode;
        else if (!bothEnc)
            next_mode = fixedMode;
        else if (isJump)
            next_mode = srcBit;
        else if (isExc)
            next_mode = excTarget;
        else if (isDebug)
            next_mode = dbgSelect;
        else if (isReturn)
            next_mode = srcBit;
    end

    // Reset release marker so straps load from synced values
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            strapLoad <= 1'b1;
        else
            strapLoad <= 1'b0;
    end

    // Mode and configuration state
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            encField  <= imc_pkg::ENC_ONLY32;
            excSelect <= '0;
            dbgSelect <= imc_pkg::MODE_32;
            mode      <= imc_pkg::MODE_32;
        end
        else if (strapLoad)
        begin
            encField  <= encSync;
            excSelect <= {imc_pkg::NUM_ELEM{excSync}};
            dbgSelect <= dbgSync;
            // same value as the mode outputs
            mode      <= next_mode;
        end
        else
        begin
            if (cfgWrite)
                excSelect[cfgWriteElem] <= cfgExcMode;
            if (probeWrite)
                dbgSelect <= probeDebugMode;
            mode <= next_mode;
        end
    end

    // Link or return word: current mode in bit 0
    // record mode in return register
    wire logic        linkMode = bothEnc ? mode : fixedMode;
    wire logic [31:0] saveWord = {req.value[31:1], linkMode};
    wire logic [31:0] jumpPc   = {req.value[31:1], 1'b0};
    wire logic        mismatch = isJump && !bothEnc && (srcBit != fixedMode);
    wire imc_pkg::imc_ra_t saveSel =
        isDebug ? imc_pkg::IMC_RA_DEBUG :
        (kind == imc_pkg::IMC_EV_ERROR) ? imc_pkg::IMC_RA_ERROR :
        imc_pkg::IMC_RA_EXC;
    wire logic saveEn = isExc || isDebug || isCall;

    wire logic resvPick = copUnimpl && next_mode && CMP_COP_AS_RESV;
    wire logic cuPick   = copUnimpl && !resvPick;

    // Registered outputs toward the pipeline
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rsp                <= '0;
            configWordThree    <= imc_pkg::RESET_WORD;
            reservedInstrFault <= 1'b0;
            copUnusableFault   <= 1'b0;
        end
        else
        begin
            rsp.nextPc    <= jumpPc;
            rsp.saveWord  <= saveWord;
            rsp.saveSel   <= saveSel;
            rsp.saveEn    <= saveEn;
            rsp.pcEn      <= isJump;
            rsp.addrFault <= mismatch;
            configWordThree <= RESET_WORD_W(encField,
                                            excSelect[cfgWriteElem]);
            reservedInstrFault <= resvPick;
            copUnusableFault   <= cuPick;
        end
    end

    // Build the visible config word
    function automatic logic [31:0] RESET_WORD_W(input logic [1:0] enc,
                                                 input logic exc);
        RESET_WORD_W = imc_pkg::RESET_WORD;
        RESET_WORD_W[imc_pkg::CFG_ENC_LSB +: 2] = enc;
        RESET_WORD_W[imc_pkg::CFG_EXC_BIT]      = exc;
    endfunction : RESET_WORD_W

    // Mode-dependent decode, alignment and offset scaling
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            isaMode         <= imc_pkg::MODE_32;
            decodeCompact   <= 1'b0;
            fetchHalfAlign  <= 1'b0;
            offsetShift     <= imc_pkg::SHIFT_32;
            debugModeSelect <= 1'b0;
        end
        else
        begin
            isaMode         <= next_mode;
            decodeCompact   <= next_mode;
            fetchHalfAlign  <= next_mode;
            offsetShift     <= next_mode ? imc_pkg::SHIFT_CMP
                                         : imc_pkg::SHIFT_32;
            debugModeSelect <= dbgSelect;
        end
    end

    // Named sequences for the multi-step checks
    sequence s_exc_taken;
        !strapLoad && bothEnc && isExc && req.baseVec;
    endsequence
    sequence s_cfg_written;
        !strapLoad && cfgWrite ##1 cfgWriteElem == $past(cfgWriteElem);
    endsequence

    a_jump_mode_set: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && bothEnc && isJump |=> isaMode == $past(srcBit))
        else $error("Jump did not take mode from bit 0");

    a_jump_pc_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        isJump |=> rsp.pcEn && !rsp.nextPc[0])
        else $error("Jump target bit 0 not cleared");

    a_exc_save_order: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_exc_taken |=> rsp.saveEn && rsp.saveWord[0] == $past(mode)
                        && isaMode == $past(excSelect[req.elem]))
        else $error("Exception save or switch wrong");

    a_debug_mode_sel: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && bothEnc && isDebug |=> isaMode == $past(dbgSelect))
        else $error("Debug exception mode wrong");

    a_return_restore: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && bothEnc && isReturn |=> isaMode == $past(srcBit))
        else $error("Return did not restore mode");

    a_single_fixed: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && !bothEnc ##1 !strapLoad |-> isaMode == fixedMode)
        else $error("Single-encoding mode moved");

    a_mismatch_fault: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mismatch |=> rsp.addrFault)
        else $error("Missing address fault");

    a_shift_by_mode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        offsetShift == (isaMode ? imc_pkg::SHIFT_CMP : imc_pkg::SHIFT_32))
        else $error("Offset shift does not match mode");

    a_call_link_mode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        isCall |=> rsp.saveWord[0] == $past(isaMode))
        else $error("Call link bit wrong");

    a_cfg_enc_field: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ##1 configWordThree[15:14] == $past(encField))
        else $error("Encoding field not reported");

    a_reset_mode_load: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        strapLoad |=> isaMode == $past(strapMode))
        else $error("Reset mode not taken from straps");

    a_cfg_exc_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_written |=> configWordThree[imc_pkg::CFG_EXC_BIT] ==
                          $past(cfgExcMode, 2))
        else $error("Exception select write not shown");

    a_exc_nonbase_keep: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && isExc && !req.baseVec |=> isaMode == $past(isaMode))
        else $error("Non-base exception moved the mode");

    a_elem_select_sep: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && cfgWrite |=> excSelect == ($past(cfgWriteElem)
            ? {$past(cfgExcMode), $past(excSelect[0])}
            : {$past(excSelect[1]), $past(cfgExcMode)}))
        else $error("Processor element selects not separate");

    a_fetch_follows_jump: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && bothEnc && isJump |=> decodeCompact == $past(srcBit)
            && fetchHalfAlign == $past(srcBit))
        else $error("Decoder or fetch alignment lags mode");

    a_exc_record_mode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        isExc || isDebug |=> rsp.saveEn && rsp.saveWord[0] == $past(isaMode))
        else $error("Return register lacks the mode");

    a_call_single_link: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && !bothEnc && isCall |=>
            rsp.saveEn && rsp.saveWord[0] == $past(fixedMode))
        else $error("Single-encoding call link bit wrong");

    a_shift_compact: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !strapLoad && bothEnc && isJump && srcBit |=>
            offsetShift == imc_pkg::SHIFT_CMP)
        else $error("Compressed offset shift wrong");

    a_cop_fault_pick: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        copUnimpl |=> reservedInstrFault == (isaMode && CMP_COP_AS_RESV)
                      && copUnusableFault == !reservedInstrFault)
        else $error("Coprocessor fault choice wrong");

endmodule : imc_mode_control

// >>> imc_strap_probe.sv
/*
 * Strap pins and debug probe that face the mode control block.
 * Assumes the bench calls its tasks just after a falling clock edge.
 */
module imc_strap_probe (
    output logic [1:0] strapEncoding,
    output logic       strapExcMode,
    output logic       strapDebugMode,
    output logic       probeWrite,
    output logic       probeDebugMode
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lastValue;

    // Pins start as a part with both encodings
    initial
    begin
        strapEncoding = 2'h2;
        strapExcMode = 1'h0;
        strapDebugMode = 1'h0;
        probeWrite = 1'h0;
        lastValue = 1'h0;
        probeDebugMode = 1'h1;
    end

    task automatic set_straps(input logic [1:0] enc, input logic exc,
                              input logic dbg);
        strapEncoding = enc;
        strapExcMode = exc;
        strapDebugMode = dbg;
    endtask : set_straps

    task automatic probe_write(input logic en, input logic value);
        probeWrite = en;
        if (en)
        begin
            lastValue = value;
            probeDebugMode = value;
        end
        else
            probeDebugMode = ~lastValue; // Released line shows stale inverse
    endtask : probe_write
endmodule : imc_strap_probe

// >>> testbench.sv
/*
 * Self-checking bench for the mode control block with a reference model.
 * Assumes the strap and probe model drives the pins on bench request.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk;
    logic              rst_n;
    logic [1:0]        strapEncoding;
    logic              strapExcMode, strapDebugMode;
    logic              probeWrite, probeDebugMode;
    logic              cfgWrite, cfgWriteElem, cfgExcMode, copUnimpl;
    imc_pkg::imc_req_t req;
    logic [31:0]       configWordThree;
    logic              isaMode, decodeCompact, fetchHalfAlign;
    logic [1:0]        offsetShift;
    logic              debugModeSelect;
    logic              reservedInstrFault, copUnusableFault;
    imc_pkg::imc_rsp_t rsp;
    int                mismatches = 0;
    int                tests_run = 0;
    int                cycles = 0;
    int                mode, prevMode, dbgSel, single, enc, quiet;
    int                prevKind, prevCop, prevDbg;
    int                excSel [2];
    logic [31:0]       prevValue;

    imc_strap_probe probe (.strapEncoding, .strapExcMode, .strapDebugMode,
                           .probeWrite, .probeDebugMode);

    imc_mode_control #(.CMP_COP_AS_RESV(1'b1)) dut (
        .core_clk, .rst_n, .strapEncoding, .strapExcMode, .strapDebugMode,
        .probeWrite, .probeDebugMode, .cfgWrite, .cfgWriteElem, .cfgExcMode,
        .req, .copUnimpl, .configWordThree, .isaMode, .decodeCompact,
        .fetchHalfAlign, .offsetShift, .debugModeSelect, .reservedInstrFault,
        .copUnusableFault, .rsp);

    // Core clock, 40 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // Reset with new straps, then seed the model
    task automatic do_reset(input int e);
        logic [31:0] r;
        @(negedge core_clk);
        r = $urandom;
        rst_n = 1'b0;
        req = '0;
        cfgWrite = 1'b0;
        copUnimpl = 1'b0;
        probe.set_straps(e[1:0], r[0], r[1]);
        probe.probe_write(1'b0, r[2]);
        repeat (16) @(negedge core_clk);
        check(configWordThree, 32'h0000_0000);
        check(offsetShift, 2'h2);
        rst_n = 1'b1;
        enc = e;
        single = (e < 2);
        mode = e % 2;
        prevMode = mode;
        dbgSel = r[1];
        prevDbg = r[1];
        excSel[0] = r[0];
        excSel[1] = r[0];
        prevKind = 0;
        prevCop = 0;
        quiet = 0;
        // Let the strap load edge pass with no event
        @(negedge core_clk);
    endtask : do_reset

    // Compare last edge's results, then drive a random event
    task automatic step();
        logic [31:0] r;
        int          k;
        logic        changed;
        @(negedge core_clk);
        check(isaMode, mode);
        check(decodeCompact, mode);
        check(fetchHalfAlign, mode);
        check(offsetShift, mode ? 2'h1 : 2'h2);
        check(debugModeSelect, prevDbg);
        check(configWordThree[15:14], enc);
        check({configWordThree[31:17], configWordThree[13:0]}, 0);
        if (quiet >= 2)
            check(configWordThree[16], excSel[cfgWriteElem]);
        check(reservedInstrFault, prevCop && prevMode == 1);
        check(copUnusableFault, prevCop && prevMode == 0);
        // Kinds: 1 exc, 2 debug, 3 error, 4 jump, 5 call, 6 return
        if (prevKind == 4 || prevKind == 5)
        begin
            check(rsp.pcEn, 1);
            check(rsp.nextPc, prevValue & 32'hFFFF_FFFE);
            check(rsp.addrFault, single && prevValue[0] != prevMode);
            check(rsp.saveEn, prevKind == 5);
            if (prevKind == 5)
                check(rsp.saveWord, {prevValue[31:1], prevMode[0]});
        end
        if (prevKind >= 1 && prevKind <= 3)
        begin
            check(rsp.saveEn, 1);
            check(rsp.saveWord, {prevValue[31:1], prevMode[0]});
            check(rsp.saveSel, prevKind - 1);
        end
        if (prevKind == 0)
            check(rsp.saveEn | rsp.pcEn, 0);
        if (prevKind == 6)
            check(rsp.saveEn | rsp.pcEn, 0);
        k = $urandom_range(9);
        if (k > 6)
            k = 0;
        r = $urandom;
        req.kind = imc_pkg::imc_event_t'(k);
        req.value = $urandom;
        req.elem = r[0];
        req.baseVec = (k == 1) ? r[1] : 1'b1;
        copUnimpl = (k == 0) && r[2];
        changed = cfgWrite;
        cfgWrite = (k == 0) && r[3];
        cfgExcMode = r[4];
        if (r[7:5] == 3'h0)
        begin
            cfgWriteElem = ~cfgWriteElem;
            changed = 1'b1;
        end
        quiet = (changed || cfgWrite) ? 0 : quiet + 1;
        probe.probe_write((k == 0) && r[8], r[9]);
        prevMode = mode;
        prevKind = k;
        prevValue = req.value;
        prevCop = copUnimpl;
        prevDbg = dbgSel;
        if (!single)
        begin
            if (k >= 4)
                mode = req.value[0];
            if ((k == 1 && req.baseVec) || k == 3)
                mode = excSel[req.elem];
            if (k == 2)
                mode = dbgSel;
        end
        if (cfgWrite)
            excSel[cfgWriteElem] = cfgExcMode;
        if (k == 0 && r[8])
            dbgSel = r[9];
    endtask : step

    // Main sequence over all four encoding straps
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        cfgWrite = 1'b0;
        cfgWriteElem = 1'b0;
        cfgExcMode = 1'b0;
        copUnimpl = 1'b0;
        void'($urandom(32'h92D2A345));
        for (int e = 0; e < 4; e++)
        begin
            do_reset(e);
            repeat (150) step();
        end
        tally_and_finish();
    end

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
endmodule : testbench
